// file: hw/adcsr_pkg.sv
// shared constants and types for the serial converter control link
package adcsr_pkg;

  // ***************************************************************
  // word layout
  // ***************************************************************
  localparam int         WORD_W   = 16;
  localparam int         DATA_W   = 14;
  localparam int         RES_W    = 12;
  localparam int         CAL_N    = 10;
  localparam logic [3:0] CAL_LAST = 4'h9;

  // write target codes in the two top bits of a frame
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_TEST = 2'h1;
  localparam logic [1:0] TGT_CAL  = 2'h2;
  localparam logic [1:0] TGT_CTRL = 2'h3;

  // read source codes
  localparam logic [1:0] SRC_DATA = 2'h0;
  localparam logic [1:0] SRC_TEST = 2'h1;
  localparam logic [1:0] SRC_CAL  = 2'h2;
  localparam logic [1:0] SRC_STAT = 2'h3;

  // control field positions
  localparam int C_SGL   = 13;
  localparam int C_CH_HI = 12;
  localparam int C_CH_LO = 10;
  localparam int C_PM_HI = 9;
  localparam int C_PM_LO = 8;
  localparam int C_RD_HI = 7;
  localparam int C_RD_LO = 6;
  localparam int C_MODE  = 5;
  localparam int C_CONV  = 4;
  localparam int C_CALMD = 3;
  localparam int C_STCAL = 0;

  // reset values, and the full power-down code
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [13:0] TEST_RST = 14'h0000;
  localparam logic [13:0] CAL_RST  = 14'h0000;
  localparam logic [1:0]  PM_FULL  = 2'h2;

  // ***************************************************************
  // timing, in master clock periods, nanoseconds and pclk cycles
  // ***************************************************************
  localparam logic [7:0] CONV_TICKS     = 8'h10;
  localparam logic [7:0] CAL_TICKS      = 8'h40;
  localparam int         LINK_PERIOD_NS = 400;
  localparam int         PCLK_PERIOD_NS = 50;
  localparam int         HALF_CYC = LINK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

  // ***************************************************************
  // host register map
  // ***************************************************************
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_RX    = 8'h08;
  localparam logic [7:0] OFS_IRQ   = 8'h0C;
  localparam logic [7:0] OFS_MASK  = 8'h10;
  localparam int         CMD_TWO_WIRE = 16;
  localparam int         IRQ_DONE = 0;
  localparam int         IRQ_IDLE = 1;

  // ***************************************************************
  // state types
  // ***************************************************************
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_CAL  = 2'b10
  } adcsr_seq_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LEAD = 3'b001,
    HST_HIGH = 3'b010,
    HST_LOW  = 3'b011,
    HST_TAIL = 3'b100,
    HST_GAP  = 3'b101
  } adcsr_host_st_t;

  // rising edge between a synchronised level and its delayed copy
  function automatic logic adcsr_rise(logic now_v, logic was_v);
    return now_v & ~was_v;
  endfunction : adcsr_rise

endpackage : adcsr_pkg

// file: hw/adcsr_if.sv
// serial link between the converter control and its host
`timescale 1ns/1ns
interface adcsr_if;
  logic sync_n;
  logic sclk;
  logic din_host;
  logic din_host_oe;
  logic din_dev;
  logic din_dev_oe;
  logic din;
  logic dout;
  logic busy;

  // resolved level of the two-way data input, idles high
  assign din = din_dev_oe  ? din_dev  :
               din_host_oe ? din_host : 1'b1;

  modport dev (
    input  sync_n, sclk, din,
    output din_dev, din_dev_oe, dout, busy
  );

  modport host (
    output sync_n, sclk, din_host, din_host_oe,
    input  din, dout, busy
  );
endinterface : adcsr_if

// file: hw/adcsr_device.sv
// converter side: serial registers, conversion and calibration timing
`timescale 1ns/1ns

// How it works
// RQ1: cal pin low resets cal; rise starts cal
// RQ2: calibration request overrides any conversion
// RQ3: each read returns a 16-bit serial word
// RQ4: write word 16 bits; data pin two-way
// RQ5: frame select low frames clocks; else ignored
// RQ6: host alone makes the serial clock
// RQ7: conversion and calibration timed by master clock
// RQ8: defaults at reset; channel write suffices
// RQ9: control, data, status, test, ten cal registers
// RQ10: host never writes the test register; a TGT_TEST write still loads test_reg
// RQ11: defaults allow power-down and self calibration
// RQ12: writes pick power, cal type, soft start
// RQ13: control field picks channel arrangement
// RQ14: two target bits, fourteen data, latch last
// RQ15: read source field routes reads, default data
// RQ16: busy high from start to completion
// RQ17: words move msb first, one bit per clock
module adcsr_device (
  // clock, reset, enable
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      ce,
  // serial link
  adcsr_if.dev                           link,
  // converter pins
  input  wire logic                      master_clock_in,
  input  wire logic                      cal_request_n,
  input  wire logic                      conversion_trigger,
  input  wire logic                      sleep_n,
  input  wire logic [adcsr_pkg::RES_W-1:0] sample,
  // configuration seen by the analog side
  output logic      [2:0]                channel,
  output logic                           single_ended,
  output logic                           cal_system,
  output logic                           powered_down
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam logic [6:0] SY_RST = 7'h45;

  logic [6:0]  sy_raw;
  logic [6:0]  sy1;
  logic [6:0]  sy2;
  logic [6:0]  sy3;

  assign sy_raw = {link.sync_n, link.sclk, link.din, master_clock_in,
                   cal_request_n, conversion_trigger, sleep_n};

  // two stages, then a delayed copy for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= SY_RST;
      sy2 <= SY_RST;
      sy3 <= SY_RST;
    end else if (ce) begin
      sy1 <= sy_raw;
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // ***************************************************************
  // decoded events
  // ***************************************************************
  logic        frame;
  logic        frame_start;
  logic        sck_rise;
  logic        sck_fall;
  logic        din_s;
  logic        mclk_rise;
  logic        cal_hold;
  logic        cal_rise;
  logic        conv_rise;
  logic        sleep_s;

  assign frame       = ~sy2[6];
  assign frame_start = adcsr_pkg::adcsr_rise(sy3[6], sy2[6]);
  assign din_s       = sy2[4];
  assign mclk_rise   = adcsr_pkg::adcsr_rise(sy2[3], sy3[3]); // RQ7
  assign cal_hold    = ~sy2[2];
  assign cal_rise    = adcsr_pkg::adcsr_rise(sy2[2], sy3[2]); // RQ1
  assign conv_rise   = adcsr_pkg::adcsr_rise(sy2[1], sy3[1]);
  assign sleep_s     = sy2[0];

  // ***************************************************************
  // registers and state
  // ***************************************************************
  logic [13:0] ctrl;
  logic [13:0] test_reg;
  logic [13:0] cal_reg [adcsr_pkg::CAL_N];
  logic [3:0]  cal_ptr;
  logic [11:0] result;
  logic [11:0] held;
  logic [14:0] rx;
  logic [15:0] tx;
  logic [4:0]  bitcnt;
  logic        two_wire;
  logic [7:0]  ticks;
  adcsr_pkg::adcsr_seq_t seq;

  // clocks outside a frame, and rising clocks past sixteen, are ignored
  assign sck_rise = adcsr_pkg::adcsr_rise(sy2[5], sy3[5]) & frame
                    & ~bitcnt[4]; // RQ5
  assign sck_fall = adcsr_pkg::adcsr_rise(sy3[5], sy2[5]) & frame; // RQ5

  // ***************************************************************
  // write decode
  // ***************************************************************
  logic        word_done;
  logic [15:0] wword;
  logic [1:0]  tgt;
  logic [13:0] wdata;
  logic        wr_ok;
  logic        wr_ctrl;
  logic        wr_cal;
  logic        wr_test;
  logic        soft_conv;
  logic        soft_cal;
  logic        conv_end;
  logic        cal_end;
  logic        busy;
  logic [1:0]  rd_src;

  // whole word known only on the sixteenth rising clock
  assign word_done = sck_rise && bitcnt == 5'h0F; // RQ14
  assign wword     = {rx, din_s};
  assign tgt       = wword[15:14]; // RQ14
  assign wdata     = wword[13:0];
  assign wr_ok     = word_done & ~two_wire;
  assign wr_ctrl   = wr_ok && tgt == adcsr_pkg::TGT_CTRL;
  assign wr_cal    = wr_ok && tgt == adcsr_pkg::TGT_CAL;
  assign wr_test   = wr_ok && tgt == adcsr_pkg::TGT_TEST;
  assign soft_conv = wr_ctrl & wdata[adcsr_pkg::C_CONV]; // RQ12
  assign soft_cal  = wr_ctrl & wdata[adcsr_pkg::C_STCAL]; // RQ12
  assign rd_src    = ctrl[adcsr_pkg::C_RD_HI:adcsr_pkg::C_RD_LO];

  // serial bit counter and input shifter, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt <= 5'h00;
      rx     <= 15'h0000;
    end else if (ce) begin
      if (frame_start) begin
        bitcnt <= 5'h00;
      end else if (sck_rise) begin
        bitcnt <= bitcnt + 5'h01;
        rx     <= {rx[13:0], din_s}; // RQ17
      end
    end
  end

  // control register, mode and start bits self-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= adcsr_pkg::CTRL_RST; // RQ8
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= wdata; // RQ14
      end else begin
        if (word_done) ctrl[adcsr_pkg::C_MODE] <= 1'b0;
        if (conv_end || cal_hold) ctrl[adcsr_pkg::C_CONV] <= 1'b0;
        if (cal_end || cal_hold) ctrl[adcsr_pkg::C_STCAL] <= 1'b0;
      end
    end
  end

  // test and calibration registers, pointer walks the ten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_reg <= adcsr_pkg::TEST_RST;
      cal_ptr  <= 4'h0;
      for (int i = 0; i < adcsr_pkg::CAL_N; i++) begin
        cal_reg[i] <= adcsr_pkg::CAL_RST;
      end
    end else if (ce) begin
      if (wr_test) test_reg <= wdata; // RQ9
      if (wr_cal) cal_reg[cal_ptr] <= wdata; // RQ9
      if (wr_ctrl) begin
        cal_ptr <= 4'h0;
      end else if (wr_cal || (word_done && rd_src == adcsr_pkg::SRC_CAL)) begin
        cal_ptr <= (cal_ptr == adcsr_pkg::CAL_LAST) ? 4'h0
                                                    : cal_ptr + 4'h1;
      end
    end
  end

  // ***************************************************************
  // conversion and calibration sequencer
  // ***************************************************************
  assign conv_end = seq == adcsr_pkg::SEQ_CONV && mclk_rise
                    && ticks == adcsr_pkg::CONV_TICKS - 8'h01; // RQ7
  assign cal_end  = seq == adcsr_pkg::SEQ_CAL && mclk_rise
                    && ticks == adcsr_pkg::CAL_TICKS - 8'h01; // RQ7
  assign busy     = seq != adcsr_pkg::SEQ_IDLE;

  // calibration pin holds the sequencer and beats conversions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq   <= adcsr_pkg::SEQ_IDLE;
      ticks <= 8'h00;
    end else if (ce) begin
      if (cal_hold) begin
        seq   <= adcsr_pkg::SEQ_IDLE; // RQ1
        ticks <= 8'h00;
      end else if (cal_rise || soft_cal) begin
        seq   <= adcsr_pkg::SEQ_CAL; // RQ2
        ticks <= 8'h00;
      end else begin
        unique case (seq)
          adcsr_pkg::SEQ_IDLE: begin
            if (conv_rise || soft_conv) begin
              seq   <= adcsr_pkg::SEQ_CONV;
              ticks <= 8'h00;
            end
          end
          adcsr_pkg::SEQ_CONV: begin
            if (conv_end) seq <= adcsr_pkg::SEQ_IDLE;
            else if (mclk_rise) ticks <= ticks + 8'h01;
          end
          adcsr_pkg::SEQ_CAL: begin
            if (cal_end) seq <= adcsr_pkg::SEQ_IDLE;
            else if (mclk_rise) ticks <= ticks + 8'h01;
          end
          default: seq <= adcsr_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  // sample held at start, published at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held   <= 12'h000;
      result <= 12'h000;
    end else if (ce) begin
      if (seq == adcsr_pkg::SEQ_IDLE && !cal_hold && !cal_rise
          && !soft_cal && (conv_rise || soft_conv)) held <= sample;
      if (conv_end) result <= held;
    end
  end

  // ***************************************************************
  // read path
  // ***************************************************************
  logic [15:0] next_tx;

  // read source mux, data carries four leading zeros
  always_comb begin
    unique case (rd_src) // RQ15
      adcsr_pkg::SRC_DATA: next_tx = {4'h0, result};
      adcsr_pkg::SRC_TEST: next_tx = {2'h0, test_reg};
      adcsr_pkg::SRC_CAL:  next_tx = {2'h0, cal_reg[cal_ptr]};
      adcsr_pkg::SRC_STAT: next_tx = {2'h0, ctrl[13:8], seq, cal_ptr,
                                      powered_down, sleep_s};
    endcase
  end

  // output word loaded at frame start, shifted on falling clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx       <= 16'h0000;
      two_wire <= 1'b0;
    end else if (ce) begin
      if (frame_start) begin
        tx       <= next_tx; // RQ3
        two_wire <= ctrl[adcsr_pkg::C_MODE];
      end else if (sck_fall) begin
        tx <= {tx[14:0], 1'b0}; // RQ17
      end
    end
  end

  // pins; data pin turns round only in two-wire frames
  assign link.dout       = tx[15]; // RQ3
  assign link.din_dev    = tx[15];
  assign link.din_dev_oe = frame & ~frame_start & two_wire; // RQ4
  assign link.busy       = busy; // RQ16

  // configuration to the analog side
  assign channel      = ctrl[adcsr_pkg::C_CH_HI:adcsr_pkg::C_CH_LO];
  assign single_ended = ctrl[adcsr_pkg::C_SGL]; // RQ13
  assign cal_system   = ctrl[adcsr_pkg::C_CALMD]; // RQ12
  assign powered_down = ~busy & (~sleep_s |
    (ctrl[adcsr_pkg::C_PM_HI:adcsr_pkg::C_PM_LO] == adcsr_pkg::PM_FULL)); // RQ11

endmodule : adcsr_device

// file: hw/adcsr_host.sv
// host side: apb command registers driving the serial link
`timescale 1ns/1ns
module adcsr_host (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // serial link
  adcsr_if.host            link
);

  // ***************************************************************
  // synchronisers for dout, din and busy
  // ***************************************************************
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic       busy_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1    <= 3'h4;
      sy2    <= 3'h4;
      busy_d <= 1'b0;
    end else if (ce) begin
      sy1    <= {link.din, link.busy, link.dout};
      sy2    <= sy1;
      busy_d <= sy2[1];
    end
  end

  // ***************************************************************
  // apb decode
  // ***************************************************************
  logic        wr;
  logic        mapped;
  logic        cmd_go;
  logic        half_done;
  logic        done_ev;
  logic        idle_ev;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [15:0] tx;
  logic [15:0] rx;
  logic [15:0] rx_word;
  logic [2:0]  div;
  logic [3:0]  bitn;
  logic        two_wire;
  logic        sync_n;
  logic        sclk;
  adcsr_pkg::adcsr_host_st_t st;

  assign mapped  = paddr == adcsr_pkg::OFS_CMD  || paddr == adcsr_pkg::OFS_STAT
                || paddr == adcsr_pkg::OFS_RX   || paddr == adcsr_pkg::OFS_IRQ
                || paddr == adcsr_pkg::OFS_MASK;
  assign wr      = psel & penable & pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // commands while a frame runs are dropped
  assign cmd_go  = wr && paddr == adcsr_pkg::OFS_CMD
                   && st == adcsr_pkg::HST_IDLE;

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      adcsr_pkg::OFS_STAT: prdata = {30'h0, sy2[1],
                                     st != adcsr_pkg::HST_IDLE};
      adcsr_pkg::OFS_RX:   prdata = {16'h0000, rx_word};
      adcsr_pkg::OFS_IRQ:  prdata = {30'h0, irq_stat};
      adcsr_pkg::OFS_MASK: prdata = {30'h0, irq_mask};
      default:             prdata = 32'h0000_0000;
    endcase
  end

  // ***************************************************************
  // frame sequencer, host makes the serial clock
  // ***************************************************************
  assign half_done = div == 3'(adcsr_pkg::HALF_CYC - 1);
  assign done_ev   = st == adcsr_pkg::HST_TAIL && half_done;
  assign idle_ev   = adcsr_pkg::adcsr_rise(busy_d, sy2[1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= adcsr_pkg::HST_IDLE;
      div      <= 3'h0;
      bitn     <= 4'h0;
      tx       <= 16'h0000;
      rx       <= 16'h0000;
      rx_word  <= 16'h0000;
      two_wire <= 1'b0;
      sync_n   <= 1'b1;
      sclk     <= 1'b0;
    end else if (ce) begin
      div <= half_done ? 3'h0 : div + 3'h1;
      unique case (st)
        adcsr_pkg::HST_IDLE: begin
          div <= 3'h0;
          if (cmd_go) begin
            tx       <= pwdata[15:0];
            two_wire <= pwdata[adcsr_pkg::CMD_TWO_WIRE];
            sync_n   <= 1'b0; // RQ5
            bitn     <= 4'h0;
            st       <= adcsr_pkg::HST_LEAD;
          end
        end
        adcsr_pkg::HST_LEAD, adcsr_pkg::HST_LOW: begin
          if (half_done) begin
            sclk <= 1'b1; // RQ6
            st   <= adcsr_pkg::HST_HIGH;
          end
        end
        adcsr_pkg::HST_HIGH: begin
          if (half_done) begin
            rx   <= {rx[14:0], two_wire ? sy2[2] : sy2[0]}; // RQ17
            tx   <= {tx[14:0], 1'b0};
            sclk <= 1'b0;
            bitn <= bitn + 4'h1;
            st   <= (bitn == 4'hF) ? adcsr_pkg::HST_TAIL
                                   : adcsr_pkg::HST_LOW;
          end
        end
        adcsr_pkg::HST_TAIL: begin
          if (half_done) begin
            sync_n  <= 1'b1;
            rx_word <= rx;
            st      <= adcsr_pkg::HST_GAP;
          end
        end
        adcsr_pkg::HST_GAP: begin
          if (half_done) st <= adcsr_pkg::HST_IDLE;
        end
        default: st <= adcsr_pkg::HST_IDLE;
      endcase
    end
  end

  // sticky events, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else if (ce) begin
      if (wr && paddr == adcsr_pkg::OFS_MASK) irq_mask <= pwdata[1:0];
      irq_stat <= (irq_stat & ~((wr && paddr == adcsr_pkg::OFS_IRQ)
                                ? pwdata[1:0] : 2'h0))
                  | {idle_ev, done_ev};
    end
  end

  assign irq              = |(irq_stat & irq_mask);
  assign link.sync_n      = sync_n;
  assign link.sclk        = sclk;
  assign link.din_host    = tx[15]; // RQ4
  assign link.din_host_oe = ~sync_n & ~two_wire; // RQ4

endmodule : adcsr_host

// file: testbench/adcsr_link_chk.sv
// concurrent checks on the serial link between host end and converter end
`timescale 1ns/1ns
module adcsr_link_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din_dev_oe,
  input wire logic din_host_oe,
  input wire logic dout,
  input wire logic busy
);
  logic [4:0] rises;
  logic [9:0] busy_run;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // sclk rises seen inside the current frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rises <= 5'h00;
    else if (sync_n) rises <= 5'h00;
    else if ($rose(sclk)) rises <= rises + 5'h01;
  end

  // length of the current busy run, a stuck busy overruns it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_run <= 10'h000;
    else if (busy) busy_run <= busy_run + 10'h001;
    else busy_run <= 10'h000;
  end

  // ***************************************************************
  // link timing
  // ***************************************************************
  sequence s_lead;
    !sclk [*4];
  endsequence
  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence

  AST_SCLK_FRAMED: assert property (sync_n |-> !sclk)
    else $error("sclk high outside a frame");
  AST_LEAD_QUIET: assert property ($fell(sync_n) |-> s_lead)
    else $error("sclk moved too early after frame start");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> s_high_half)
    else $error("sclk high phase not four cycles");
  AST_FRAME_BITS: assert property ($rose(sync_n) |-> rises == 5'h10)
    else $error("frame did not carry sixteen clocks");
  AST_FRAME_GAP: assert property ($rose(sync_n) |-> sync_n [*4])
    else $error("frame gap too short");
  AST_ONE_DRIVER: assert property (!(din_dev_oe && din_host_oe))
    else $error("both ends drive din");
  AST_DEV_RELEASE: assert property ($rose(sync_n) |-> ##4 !din_dev_oe)
    else $error("device kept din after frame");
  AST_DOUT_HOLD: assert property (
    !sync_n && sclk && $past(sclk) |-> $stable(dout))
    else $error("dout changed while sclk high");
  AST_BUSY_MIN: assert property ($rose(busy) |-> busy [*8])
    else $error("busy pulse too short");
  AST_BUSY_MAX: assert property (busy_run < 10'h2BC)
    else $error("busy held too long");
endmodule : adcsr_link_chk

// file: testbench/adc_serial_register_control_tb.sv
// self-checking bench: apb host end driving the converter end over the link
`timescale 1ns/1ns
module adc_serial_register_control_tb;
  // ***************************************************************
  // stimulus, ends and checker
  // ***************************************************************
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        master_clock_in = 1'b0;
  logic        cal_request_n = 1'b1;
  logic        conversion_trigger = 1'b0;
  logic        sleep_n = 1'b1;
  logic [11:0] sample = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdv;
  logic [15:0] rx;
  logic [2:0]  channel;
  logic        pready, pslverr, irq, errv, sgl, calsys, pdown;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;

  // bus clock and a master clock of unrelated phase
  always #25 pclk = ~pclk;
  initial begin
    #13;
    forever #200 master_clock_in = ~master_clock_in;
  end

  adcsr_if i_adcsr_if ();
  adcsr_device i_adcsr_device (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .link(i_adcsr_if), .master_clock_in(master_clock_in),
    .cal_request_n(cal_request_n), .conversion_trigger(conversion_trigger),
    .sleep_n(sleep_n), .sample(sample), .channel(channel),
    .single_ended(sgl), .cal_system(calsys), .powered_down(pdown));
  adcsr_host i_adcsr_host (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .link(i_adcsr_if));
  adcsr_link_chk i_adcsr_link_chk (.pclk(pclk), .presetn(presetn),
    .sync_n(i_adcsr_if.sync_n), .sclk(i_adcsr_if.sclk),
    .din_dev_oe(i_adcsr_if.din_dev_oe), .din_host_oe(i_adcsr_if.din_host_oe),
    .dout(i_adcsr_if.dout), .busy(i_adcsr_if.busy));
  wire busy = i_adcsr_if.busy;

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link frame: order it, wait for its interrupt, clear, fetch word
  task automatic frame(input logic [31:0] cmd);
    apb(1'b1, adcsr_pkg::OFS_CMD, cmd);
    while (irq !== 1'b1) begin
      @(negedge pclk);
    end
    apb(1'b1, adcsr_pkg::OFS_IRQ, 32'h00000001);
    apb(1'b0, adcsr_pkg::OFS_RX, 32'h00000000);
    rx = rdv[15:0];
    chk("irq after clear", 32'h00000000, {31'h0, irq});
  endtask : frame

  // wait for busy to rise, then count its high cycles
  task automatic busy_len(output int m);
    m = 0;
    while (busy !== 1'b1) begin
      @(negedge pclk);
    end
    while (busy === 1'b1) begin
      @(negedge pclk);
      m++;
    end
  endtask : busy_len

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // cycle ceiling against a hang
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, adcsr_pkg::OFS_MASK, 32'h00000001);
    apb(1'b0, 8'h14, 32'h00000000);
    chk("unmapped err", 32'h00000001, {31'h0, errv});
    chk("unmapped data", 32'h00000000, rdv);
    @(posedge pclk);
    sample <= 12'hA5C;
    conversion_trigger <= 1'b1;
    busy_len(n);
    chk("conv time", 32'h00000001, {31'h0, n > 114 && n < 146});
    frame(32'h00000000);
    chk("data word", 32'h00000A5C, {16'h0, rx});
    apb(1'b1, adcsr_pkg::OFS_MASK, 32'h00000003);
    @(negedge pclk);
    chk("irq busy fell", 32'h00000001, {31'h0, irq});
    apb(1'b1, adcsr_pkg::OFS_IRQ, 32'h00000002);
    apb(1'b1, adcsr_pkg::OFS_MASK, 32'h00000001);
    @(negedge pclk);
    chk("irq cleared", 32'h00000000, {31'h0, irq});
    frame(32'h0000F408);
    chk("config", 32'h00000017, {27'h0, channel, sgl, calsys});
    frame(32'h0000C040);
    frame(32'h00000000);
    chk("test word", 32'h00000000, {16'h0, rx});
    frame(32'h0000C020);
    frame(32'h00010000);
    chk("two wire word", 32'h00000A5C, {16'h0, rx});
    frame(32'h00000000);
    chk("after two wire", 32'h00000A5C, {16'h0, rx});
    frame(32'h0000C000);
    for (int i = 0; i < 10; i++) frame(32'h00008100 + i);
    frame(32'h0000C080);
    for (int i = 0; i < 11; i++) begin
      frame(32'h00000000);
      chk("cal word", 32'h00000100 + i % 10, {16'h0, rx});
    end
    frame(32'h0000C1C0);
    frame(32'h00000000);
    chk("status", 32'h00000100, {16'h0, rx & 16'hFFFE});
    frame(32'h0000C200);
    chk("full power down", 32'h00000001, {31'h0, pdown});
    frame(32'h0000C000);
    chk("powered up", 32'h00000000, {31'h0, pdown});
    @(posedge pclk);
    sleep_n <= 1'b0;
    conversion_trigger <= 1'b0;
    repeat (6) @(negedge pclk);
    chk("sleep", 32'h00000001, {31'h0, pdown});
    @(posedge pclk);
    sleep_n <= 1'b1;
    conversion_trigger <= 1'b1;
    repeat (30) @(negedge pclk);
    chk("conv running", 32'h00000001, {31'h0, busy});
    @(posedge pclk);
    cal_request_n <= 1'b0;
    repeat (10) @(negedge pclk);
    chk("cal pin aborts", 32'h00000000, {31'h0, busy});
    @(posedge pclk);
    cal_request_n <= 1'b1;
    sample <= 12'h3C7;
    busy_len(n);
    chk("cal time", 32'h00000001, {31'h0, n > 499 && n < 531});
    frame(32'h0000C010);
    chk("soft start", 32'h00000001, {31'h0, busy});
    busy_len(n);
    frame(32'h00000000);
    chk("soft result", 32'h000003C7, {16'h0, rx});
    frame(32'h0000C001);
    chk("self cal", 32'h00000001, {31'h0, busy});
    busy_len(n);
    tally_and_finish();
  end
endmodule : adc_serial_register_control_tb
